// file: shared/sirc_consts.svh
// Constants for the serializer interrupt, mute and reset control block
`ifndef SIRC_CONSTS_SVH
`define SIRC_CONSTS_SVH
`define SIRC_ADDR_BLANK_CTRL 8'h04
`define SIRC_ADDR_INT_CTRL 8'hc6
`define SIRC_ADDR_INT_STATUS 8'hc7
`define SIRC_BIT_BLANK_SUPPRESS 1
`define SIRC_BIT_DOWNSTREAM 5
`define SIRC_BIT_GLOBAL 0
`define SIRC_BLANK_CTRL_RESET 8'h00
`define SIRC_INT_CTRL_RESET 8'h00
`define SIRC_STARTUP_US 1000
`define SIRC_CLK_MHZ 25
`define SIRC_PIXEL_IDLE 24'h000000
`define SIRC_MASK_BLANK_CTRL 8'h02
`define SIRC_MASK_INT_CTRL 8'h21
`define SIRC_STATUS_RSVD 8'h00
`define SIRC_UNMAPPED_READ 8'h00
`define SIRC_RDATA_RESET 8'h00
`endif

// file: shared/sirc_pkg.sv
// Types for the serializer interrupt, mute and reset control block
`default_nettype none
package sirc_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sirc_reg_req_t;
    typedef struct packed {
        logic [23:0] rgb;
        logic active;
        logic hsync;
        logic vsync;
    } sirc_pixel_t;
    typedef enum logic [1:0] {
        SIRC_OFF,
        SIRC_STARTING,
        SIRC_READY
    } sirc_power_state_t;
endpackage
`default_nettype wire

// file: hdl/sirc_sync2.sv
// Two-flop synchroniser for one level from outside the clock domain
`default_nettype none
module sirc_sync2 (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;

    // Second flop is the only reader of the first
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// file: hdl/sirc_ctrl.sv
// Interrupt status, blanking suppression and power-enable startup control
`include "sirc_consts.svh"
`default_nettype none
// How it works
// - Downstream interrupt request sets status bit 5
// - Global status bit 0 when enabled source pending
// - By default pixels pass during blanking
// - Register 0x04 bit 1 suppresses blanking video
// - Registers usable 25000 clocks (1 ms) plus two sync clocks after enable
// - Control bit 5 enables downstream interrupt source
// - Control bit 0 gates the interrupt output
module sirc_ctrl #(
    parameter int STARTUP_CYCLES = (`SIRC_STARTUP_US * `SIRC_CLK_MHZ) - 1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic chip_power_enable,
    input wire logic downstream_irq,
    input wire sirc_pkg::sirc_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    output logic reg_ready,
    input wire sirc_pkg::sirc_pixel_t pix_in,
    output sirc_pkg::sirc_pixel_t pix_out,
    output logic irq_out
);
    // Counter wide enough for the full startup count
    localparam int CW = $clog2(STARTUP_CYCLES + 1);

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    // Synchronised copies of the two pins
    logic pwr_en_s;
    logic ds_irq_s;
    // Power enable pin, high means powered
    sirc_sync2 u_sync_pwr (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(chip_power_enable),
        .sync_out(pwr_en_s)
    );
    // Downstream interrupt request level
    sirc_sync2 u_sync_irq (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(downstream_irq),
        .sync_out(ds_irq_s)
    );

    // ************************************************************
    // Power enable and startup
    // ************************************************************
    // Power state and startup counter
    sirc_pkg::sirc_power_state_t pwr_state_reg;
    logic [CW-1:0] start_cnt_reg;

    // Low pin is hard reset; count startup after it rises
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pwr_state_reg <= sirc_pkg::SIRC_OFF;
            start_cnt_reg <= '0;
        end else if (!pwr_en_s) begin
            pwr_state_reg <= sirc_pkg::SIRC_OFF;
            start_cnt_reg <= '0;
        end else begin
            case (pwr_state_reg)
                sirc_pkg::SIRC_OFF: begin
                    pwr_state_reg <= sirc_pkg::SIRC_STARTING;
                    start_cnt_reg <= '0;
                end
                sirc_pkg::SIRC_STARTING: begin
                    if (start_cnt_reg == CW'(STARTUP_CYCLES - 1)) begin
                        pwr_state_reg <= sirc_pkg::SIRC_READY;
                    end else begin
                        start_cnt_reg <= start_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    pwr_state_reg <= sirc_pkg::SIRC_READY;
                end
            endcase
        end
    end

    // Startup done; bus and pixel path open
    logic ready;
    assign ready = (pwr_state_reg == sirc_pkg::SIRC_READY);
    assign reg_ready = ready;

    // ************************************************************
    // Registers
    // ************************************************************
    // Control, status and address decode
    logic [7:0] blank_ctrl_reg;
    logic [7:0] int_ctrl_reg;
    logic ds_status_reg;
    logic acc;
    logic sel_blank;
    logic sel_int;
    logic sel_status;
    logic global_status;
    logic [7:0] status_word;
    logic [7:0] rdata_next;

    // Requests count only once startup is over
    assign acc = ready && (reg_req.wr || reg_req.rd);

    // Address decode, one select per mapped register
    always_comb begin
        sel_blank = 1'b0;
        sel_int = 1'b0;
        sel_status = 1'b0;
        if (reg_req.addr == `SIRC_ADDR_BLANK_CTRL) begin
            sel_blank = 1'b1;
        end else if (reg_req.addr == `SIRC_ADDR_INT_CTRL) begin
            sel_int = 1'b1;
        end else if (reg_req.addr == `SIRC_ADDR_INT_STATUS) begin
            sel_status = 1'b1;
        end
    end

    // Writable control registers, cleared by hard reset
    always_ff @(posedge mclk) begin
        if (sys_rst || !ready) begin
            blank_ctrl_reg <= `SIRC_BLANK_CTRL_RESET;
            int_ctrl_reg <= `SIRC_INT_CTRL_RESET;
        end else if (reg_req.wr) begin
            if (sel_blank) begin
                blank_ctrl_reg <= reg_req.wdata & `SIRC_MASK_BLANK_CTRL;
            end else if (sel_int) begin
                int_ctrl_reg <= reg_req.wdata & `SIRC_MASK_INT_CTRL;
            end
        end
    end

    // Status bit mirrors the downstream request level
    always_ff @(posedge mclk) begin
        if (sys_rst || !ready) begin
            ds_status_reg <= 1'b0;
        end else begin
            ds_status_reg <= ds_irq_s;
        end
    end

    // Global flag: any enabled source pending
    // Only one source exists in this block
    assign global_status = ds_status_reg &&
        int_ctrl_reg[`SIRC_BIT_DOWNSTREAM];

    // Status word; reserved bits read as zero
    always_comb begin
        status_word = `SIRC_STATUS_RSVD;
        status_word[`SIRC_BIT_DOWNSTREAM] = ds_status_reg;
        status_word[`SIRC_BIT_GLOBAL] = global_status;
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = `SIRC_UNMAPPED_READ;
        if (sel_blank) begin
            rdata_next = blank_ctrl_reg;
        end else if (sel_int) begin
            rdata_next = int_ctrl_reg;
        end else if (sel_status) begin
            rdata_next = status_word;
        end
    end

    // Read data and acknowledge, one cycle after request
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= `SIRC_RDATA_RESET;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= acc;
            if (acc && reg_req.rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // ************************************************************
    // Interrupt output
    // ************************************************************
    // Registered so the pin sees no decode glitches
    // Low while the global enable is off
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= global_status && int_ctrl_reg[`SIRC_BIT_GLOBAL];
        end
    end

    // ************************************************************
    // Pixel path with blanking suppression
    // ************************************************************
    sirc_pkg::sirc_pixel_t pix_next;

    // A last pixel of 666666 running into blanking would mute
    // the far end; suppression blanks rgb, sync bits still pass
    always_comb begin
        pix_next = pix_in;
        if (!pix_in.active && blank_ctrl_reg[`SIRC_BIT_BLANK_SUPPRESS]) begin
            pix_next.rgb = `SIRC_PIXEL_IDLE;
        end
    end

    // One register stage; nothing leaves before startup ends
    always_ff @(posedge mclk) begin
        if (sys_rst || !ready) begin
            pix_out <= '0;
        end else begin
            pix_out <= pix_next;
        end
    end
endmodule
`default_nettype wire

// file: testbench/sirc_ctrl_asserts.sv
// Port checks for the control block
`default_nettype none
module sirc_ctrl_asserts (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic chip_power_enable,
    input wire logic downstream_irq,
    input wire sirc_pkg::sirc_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_ready,
    input wire sirc_pkg::sirc_pixel_t pix_in,
    input wire sirc_pkg::sirc_pixel_t pix_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    req_ack_a: assert property (reg_ready && (reg_req.wr || reg_req.rd) |=> reg_ack)
        else $error("no ack");
    idle_ack_a: assert property (!reg_ready |=> !reg_ack)
        else $error("ack while off");
    stat_rsvd_a: assert property (reg_ready && reg_req.rd && reg_req.addr == 8'hc7 |=>
        reg_rdata[7:6] == 2'h0 && reg_rdata[4:1] == 4'h0) else $error("reserved set");
    stat_mirror_a: assert property ($stable(downstream_irq)[*5] ##0 reg_req.rd && reg_ready
        && $past(reg_ready) && reg_req.addr == 8'hc7 |=>
        reg_rdata[5] == $past(downstream_irq, 2))
        else $error("bit 5 wrong");
    irq_quiet_a: assert property (!downstream_irq[*7] |-> !irq_out)
        else $error("irq without source");
    pix_pass_a: assert property (pix_in.active && reg_ready |=> pix_out == $past(pix_in))
        else $error("active pixel altered");
    blank_pix_a: assert property (!pix_in.active && reg_ready |=>
        pix_out.vsync == $past(pix_in.vsync) && pix_out.hsync == $past(pix_in.hsync) &&
        !pix_out.active &&
        (pix_out.rgb == 24'h0 || pix_out.rgb == $past(pix_in.rgb))) else $error("blank wrong");
    off_idle_a: assert property (!chip_power_enable[*4] |-> !reg_ready)
        else $error("ready while off");
    cover property (irq_out);
    cover property (reg_ack && reg_rdata == 8'h21);
    cover property ($rose(reg_ready));
endmodule
bind sirc_ctrl sirc_ctrl_asserts chk_u (.*);
`default_nettype wire

// file: testbench/sirc_rx_model.sv
// Far-end receiver model: silence detector and interrupt source
`default_nettype none
module sirc_rx_model (
    input wire logic mclk,
    input wire sirc_pkg::sirc_pixel_t link_pix,
    input wire logic irq_req,
    input wire logic mute_clr,
    output logic downstream_irq,
    output logic av_silence
);
    timeunit 1ns;
    timeprecision 1ns;
    // Silence pattern in blanking mutes; request goes to the pin
    always @(posedge mclk) begin
        if (mute_clr) av_silence <= 1'b0;
        else if (!link_pix.active && link_pix.rgb == 24'h666666) av_silence <= 1'b1;
        downstream_irq <= irq_req;
    end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Bench for the control block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_power_enable = 1'b1;
    logic irq_req = 1'b0;
    logic mute_clr = 1'b1;
    logic downstream_irq, reg_ack, reg_ready, irq_out, silence;
    logic [7:0] reg_rdata;
    sirc_pkg::sirc_reg_req_t reg_req = '0;
    sirc_pkg::sirc_pixel_t pix_in = '0;
    sirc_pkg::sirc_pixel_t pix_out;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    sirc_ctrl #(.STARTUP_CYCLES(8)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .chip_power_enable(chip_power_enable), .downstream_irq(downstream_irq),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_ready(reg_ready),
        .pix_in(pix_in), .pix_out(pix_out), .irq_out(irq_out));
    sirc_rx_model rx_u (.mclk(mclk), .link_pix(pix_out), .irq_req(irq_req), .mute_clr(mute_clr),
        .downstream_irq(downstream_irq), .av_silence(silence));
    // Clock and hang guard
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // One-cycle register request, ack and read data checked
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic ak, input logic [7:0] exp);
        @(negedge mclk);
        reg_req = '{w, !w, a, d};
        @(negedge mclk);
        reg_req = '0;
        chk(24'(reg_ack), 24'(ak), "ack");
        if (!w && ak) chk(24'(reg_rdata), 24'(exp), "rdata");
    endtask
    task automatic px(input logic act, input logic [23:0] rgb, input logic [23:0] exp);
        @(negedge mclk);
        pix_in = '{rgb, act, 1'b1, 1'b1};
        @(negedge mclk);
        chk(pix_out.rgb, exp, "rgb");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        wait_n(5);
        sys_rst = 1'b0;
        mute_clr = 1'b0;
        acc(1'b0, 8'hc7, 8'h00, 1'b0, 8'h00);
        wait_n(10);
        chk(24'(reg_ready), 24'h1, "ready");
        acc(1'b0, 8'h04, 8'h00, 1'b1, 8'h00);
        acc(1'b1, 8'hc7, 8'hff, 1'b1, 8'h00);
        acc(1'b0, 8'hc7, 8'h00, 1'b1, 8'h00);
        acc(1'b0, 8'h10, 8'h00, 1'b1, 8'h00);
        px(1'b0, 24'h666666, 24'h666666);
        wait_n(1);
        chk(24'(silence), 24'h1, "silence");
        acc(1'b1, 8'h04, 8'hff, 1'b1, 8'h00);
        acc(1'b0, 8'h04, 8'h00, 1'b1, 8'h02);
        mute_clr = 1'b1;
        px(1'b0, 24'h666666, 24'h000000);
        mute_clr = 1'b0;
        wait_n(2);
        chk(24'(silence), 24'h0, "silence");
        px(1'b1, 24'h666666, 24'h666666);
        irq_req = 1'b1;
        wait_n(6);
        acc(1'b0, 8'hc7, 8'h00, 1'b1, 8'h20);
        acc(1'b1, 8'hc6, 8'h20, 1'b1, 8'h00);
        acc(1'b0, 8'hc7, 8'h00, 1'b1, 8'h21);
        chk(24'(irq_out), 24'h0, "irq");
        acc(1'b1, 8'hc6, 8'hff, 1'b1, 8'h00);
        wait_n(3);
        chk(24'(irq_out), 24'h1, "irq");
        acc(1'b0, 8'hc6, 8'h00, 1'b1, 8'h21);
        irq_req = 1'b0;
        wait_n(8);
        chk(24'(irq_out), 24'h0, "irq");
        chip_power_enable = 1'b0;
        wait_n(50000);
        acc(1'b0, 8'hc6, 8'h00, 1'b0, 8'h00);
        chip_power_enable = 1'b1;
        wait_n(12);
        acc(1'b0, 8'hc6, 8'h00, 1'b1, 8'h00);
        acc(1'b0, 8'h04, 8'h00, 1'b1, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
